// *** hw/adc_window_comparator.sv ***
// Purpose: Window detector for a 10-bit SAR converter with its limit registers
// Assumes: One clock; conversion result arrives from the analog side asynchronously
// Notes: Flag and control bits live in the converter control register
// Function
// R1: Compare each new result, set flag automatically
// R2: Flag readable bit in control register
// R3: Limits are high byte joined low byte
// R4: Limit order selects inside or outside window
// R5: Enabled flag raises interrupt request
// R6: Conversion lasts at least sixteen SAR clocks
// R7: Lower above upper means inside, else outside
`timescale 1ns/1ps
`default_nettype none
module adc_window_comparator #(
	parameter int SAR_DIV = 125
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic conv_start,
	input wire logic [adc_window_pkg::RES_W-1:0] conv_data,
	input wire logic win_irq_en,
	output logic [7:0] sfr_rdata_r,
	output logic window_hit_flag_r,
	output logic window_irq_r,
	output logic conv_busy_r,
	output logic conv_done_r
);

	// Elaboration check on the SAR divider
	if (SAR_DIV < 1)
	begin : g_bad_div
		$error("SAR_DIV must be at least 1");
	end

	localparam int CONV_CYC = adc_window_pkg::CONV_SAR_CLKS * SAR_DIV;
	localparam int CNT_W = $clog2(CONV_CYC + 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

	logic [7:0] upper_limit_low_byte_r;
	logic [7:0] upper_limit_high_byte_r;
	logic [7:0] lower_limit_low_byte_r;
	logic [7:0] lower_limit_high_byte_r;
	logic enable_r;
	logic ljst_r;
	logic [adc_window_pkg::RES_W-1:0] data_s1_r;
	logic [adc_window_pkg::RES_W-1:0] data_s2_r;
	logic [adc_window_pkg::WORD_W-1:0] result_r;
	logic [CNT_W-1:0] conv_cnt_r;
	adc_window_pkg::conv_state_e state_r;
	logic wr_ctrl;
	logic start_req;
	logic [adc_window_pkg::WORD_W-1:0] upper_word;
	logic [adc_window_pkg::WORD_W-1:0] lower_word;
	logic [adc_window_pkg::WORD_W-1:0] result_nxt;
	logic hit;
	logic [7:0] ctrl_view;

	assign wr_ctrl = sfr_wr && (sfr_addr == adc_window_pkg::CTRL_ADDR);
	// Start by pin pulse or by writing one to the busy bit
	assign start_req = enable_r && (conv_start
		|| (wr_ctrl && sfr_wdata[adc_window_pkg::CTRL_BUSY_BIT]));

	// Limit words are high byte above low byte
	assign upper_word = {upper_limit_high_byte_r, upper_limit_low_byte_r}; // R3
	assign lower_word = {lower_limit_high_byte_r, lower_limit_low_byte_r}; // R3

	// Place the result in the justification software selected
	always_comb
	begin
		if (ljst_r)
		begin
			result_nxt = {data_s2_r, {adc_window_pkg::LJST_SHIFT{1'b0}}};
		end
		else
		begin
			result_nxt = {{adc_window_pkg::LJST_SHIFT{1'b0}}, data_s2_r};
		end
	end

	// Window test: ordering of the limits picks inside or outside
	always_comb
	begin
		if (lower_word > upper_word) // R4
		begin
			hit = (result_r > upper_word) && (result_r < lower_word); // R7
		end
		else
		begin
			hit = (result_r < lower_word) || (result_r > upper_word); // R7
		end
	end

	// Limit registers written from the register port
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			upper_limit_low_byte_r <= adc_window_pkg::UPPER_LO_RST;
			upper_limit_high_byte_r <= adc_window_pkg::UPPER_HI_RST;
			lower_limit_low_byte_r <= adc_window_pkg::LOWER_LO_RST;
			lower_limit_high_byte_r <= adc_window_pkg::LOWER_HI_RST;
		end
		else if (sfr_wr)
		begin
			case (sfr_addr)
				adc_window_pkg::UPPER_LO_ADDR: upper_limit_low_byte_r <= sfr_wdata;
				adc_window_pkg::UPPER_HI_ADDR: upper_limit_high_byte_r <= sfr_wdata;
				adc_window_pkg::LOWER_LO_ADDR: lower_limit_low_byte_r <= sfr_wdata;
				adc_window_pkg::LOWER_HI_ADDR: lower_limit_high_byte_r <= sfr_wdata;
				default: ;
			endcase
		end
	end

	// Control bits written by software
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_r <= 1'b0;
			ljst_r <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			enable_r <= sfr_wdata[adc_window_pkg::CTRL_EN_BIT];
			ljst_r <= sfr_wdata[adc_window_pkg::CTRL_LJST_BIT];
		end
	end

	// Two-stage synchroniser on the analog result
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_s1_r <= '0;
			data_s2_r <= '0;
		end
		else
		begin
			data_s1_r <= conv_data;
			data_s2_r <= data_s1_r;
		end
	end

	// Conversion sequencer: hold busy for the full SAR period count, then compare
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= adc_window_pkg::ST_IDLE;
			conv_cnt_r <= '0;
			conv_busy_r <= 1'b0;
			result_r <= '0;
		end
		else
		begin
			case (state_r)
				adc_window_pkg::ST_IDLE:
				begin
					conv_cnt_r <= '0;
					if (start_req)
					begin
						state_r <= adc_window_pkg::ST_CONV;
						conv_busy_r <= 1'b1;
					end
				end
				adc_window_pkg::ST_CONV:
				begin
					conv_cnt_r <= conv_cnt_r + 1'b1;
					if (conv_cnt_r == CONV_LAST) // R6
					begin
						result_r <= result_nxt;
						state_r <= adc_window_pkg::ST_CMP;
						conv_busy_r <= 1'b0;
					end
				end
				adc_window_pkg::ST_CMP:
				begin
					state_r <= adc_window_pkg::ST_IDLE;
				end
				default:
				begin
					state_r <= adc_window_pkg::ST_IDLE;
					conv_busy_r <= 1'b0;
				end
			endcase
		end
	end

	// Sticky flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			window_hit_flag_r <= 1'b0;
			conv_done_r <= 1'b0;
		end
		else
		begin
			if (state_r == adc_window_pkg::ST_CMP && hit)
			begin
				window_hit_flag_r <= 1'b1; // R1
			end
			else if (wr_ctrl)
			begin
				window_hit_flag_r <= sfr_wdata[adc_window_pkg::CTRL_WIN_BIT];
			end
			if (state_r == adc_window_pkg::ST_CMP)
			begin
				conv_done_r <= 1'b1;
			end
			else if (wr_ctrl)
			begin
				conv_done_r <= sfr_wdata[adc_window_pkg::CTRL_DONE_BIT];
			end
		end
	end

	// Interrupt request follows the flag while enabled
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			window_irq_r <= 1'b0;
		end
		else
		begin
			window_irq_r <= window_hit_flag_r && win_irq_en; // R5
		end
	end

	// Control register view for reads
	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[adc_window_pkg::CTRL_EN_BIT] = enable_r;
		ctrl_view[adc_window_pkg::CTRL_DONE_BIT] = conv_done_r;
		ctrl_view[adc_window_pkg::CTRL_BUSY_BIT] = conv_busy_r;
		ctrl_view[adc_window_pkg::CTRL_WIN_BIT] = window_hit_flag_r; // R2
		ctrl_view[adc_window_pkg::CTRL_LJST_BIT] = ljst_r;
	end

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sfr_rdata_r <= 8'h00;
		end
		else if (sfr_rd)
		begin
			case (sfr_addr)
				adc_window_pkg::CTRL_ADDR: sfr_rdata_r <= ctrl_view;
				adc_window_pkg::UPPER_LO_ADDR: sfr_rdata_r <= upper_limit_low_byte_r;
				adc_window_pkg::UPPER_HI_ADDR: sfr_rdata_r <= upper_limit_high_byte_r;
				adc_window_pkg::LOWER_LO_ADDR: sfr_rdata_r <= lower_limit_low_byte_r;
				adc_window_pkg::LOWER_HI_ADDR: sfr_rdata_r <= lower_limit_high_byte_r;
				default: sfr_rdata_r <= 8'h00;
			endcase
		end
	end

endmodule : adc_window_comparator
`default_nettype wire

// *** hw/adc_window_pkg.sv ***
// Purpose: Shared constants for the ADC window comparator
// Assumes: 8-bit special-function register port, 10-bit conversion result
// Notes: Offsets are byte addresses on the register port
package adc_window_pkg;
	// Register addresses
	localparam logic [7:0] CTRL_ADDR = 8'hE8;
	localparam logic [7:0] UPPER_LO_ADDR = 8'hC4;
	localparam logic [7:0] UPPER_HI_ADDR = 8'hC5;
	localparam logic [7:0] LOWER_LO_ADDR = 8'hC6;
	localparam logic [7:0] LOWER_HI_ADDR = 8'hC7;
	// Reset values
	localparam logic [7:0] UPPER_LO_RST = 8'hFF;
	localparam logic [7:0] UPPER_HI_RST = 8'hFF;
	localparam logic [7:0] LOWER_LO_RST = 8'h00;
	localparam logic [7:0] LOWER_HI_RST = 8'h00;
	// Control register field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_DONE_BIT = 5;
	localparam int CTRL_BUSY_BIT = 4;
	localparam int CTRL_WIN_BIT = 1;
	localparam int CTRL_LJST_BIT = 0;
	// Result geometry
	localparam int RES_W = 10;
	localparam int WORD_W = 16;
	localparam int LJST_SHIFT = WORD_W - RES_W;
	// Conversion timing in SAR clock periods
	localparam int CONV_SAR_CLKS = 16;
	// Sequencer states, Gray coded
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_CMP = 2'h3
	} conv_state_e;
endpackage : adc_window_pkg

// *** verif/adc_window_sva.sv ***
// Purpose: Port assertions for the window comparator
// Assumes: One clock, active-low reset
// Notes: Bound into every comparator
`timescale 1ns/1ps
`default_nettype none
module adc_window_sva #(
	parameter int SAR_DIV = 125
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic conv_start,
	input wire logic win_irq_en,
	input wire logic window_hit_flag_r,
	input wire logic window_irq_r,
	input wire logic conv_busy_r,
	input wire logic conv_done_r
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic ctl_wr, set_wr, go_wr;
	logic [15:0] busy_cnt_r;
	// Control writes that set the flag or start a conversion
	assign ctl_wr = sfr_wr && sfr_addr == adc_window_pkg::CTRL_ADDR;
	assign set_wr = ctl_wr && sfr_wdata[adc_window_pkg::CTRL_WIN_BIT];
	assign go_wr = ctl_wr && sfr_wdata[adc_window_pkg::CTRL_BUSY_BIT];
	// Length of the current busy period
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_cnt_r <= 16'h0000;
		end
		else
		begin
			busy_cnt_r <= conv_busy_r ? busy_cnt_r + 16'h0001 : 16'h0000;
		end
	end
	sequence s_conv_end;
		conv_busy_r ##1 !conv_busy_r;
	endsequence
	a_busy_len: assert property (s_conv_end |-> busy_cnt_r == 16'(adc_window_pkg::CONV_SAR_CLKS * SAR_DIV))
		else $error("busy length");
	a_done_set: assert property (s_conv_end |=> conv_done_r)
		else $error("done missing");
	a_flag_cause: assert property ($rose(window_hit_flag_r) |-> $past(set_wr) ||
		($past(conv_busy_r, 2) && !$past(conv_busy_r))) else $error("flag cause");
	a_flag_hold: assert property (window_hit_flag_r && !ctl_wr |=> window_hit_flag_r)
		else $error("flag lost");
	a_irq_set: assert property (window_hit_flag_r && win_irq_en |=> window_irq_r)
		else $error("irq missing");
	a_irq_mask: assert property (window_irq_r |-> $past(win_irq_en) && $past(window_hit_flag_r))
		else $error("irq unmasked");
	a_busy_start: assert property ($rose(conv_busy_r) |-> $past(conv_start) || $past(go_wr))
		else $error("busy cause");
endmodule : adc_window_sva
bind adc_window_comparator adc_window_sva #(.SAR_DIV(SAR_DIV)) sva_u (
	.mclk(mclk),
	.rst_n(rst_n),
	.sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr),
	.sfr_wdata(sfr_wdata),
	.conv_start(conv_start),
	.win_irq_en(win_irq_en),
	.window_hit_flag_r(window_hit_flag_r),
	.window_irq_r(window_irq_r),
	.conv_busy_r(conv_busy_r),
	.conv_done_r(conv_done_r)
);
`default_nettype wire

// *** verif/adc_result_src.sv ***
// Purpose: Converter result source
// Assumes: Result wanted only during a conversion
// Notes: Idle line shows the inverse value
`timescale 1ns/1ps
`default_nettype none
module adc_result_src (
	input wire logic busy,
	input wire logic [9:0] value,
	output logic [9:0] conv_data
);
	// Hold the sample while converting, scramble it otherwise
	assign conv_data = busy ? value : ~value;
endmodule : adc_result_src
`default_nettype wire

// *** verif/adc_window_comparator_tb_top.sv ***
// Purpose: Self-checking bench for the window comparator
// Assumes: SAR divider of one
// Notes: Window cases come from a row table
`timescale 1ns/1ps
`default_nettype none
module adc_window_comparator_tb_top;
	localparam int CW = 19;
	localparam logic [7:0] CTL = adc_window_pkg::CTRL_ADDR;
	typedef struct {logic [15:0] u, l; logic [9:0] r; logic lj, hit;} row_s;
	row_s rows [8] = '{
		'{16'h0200, 16'h0100, 10'h150, 1'b0, 1'b0},
		'{16'h0200, 16'h0100, 10'h0FF, 1'b0, 1'b1},
		'{16'h0200, 16'h0100, 10'h200, 1'b0, 1'b0},
		'{16'h0200, 16'h0100, 10'h201, 1'b0, 1'b1},
		'{16'h0100, 16'h0200, 10'h150, 1'b0, 1'b1},
		'{16'h0100, 16'h0200, 10'h100, 1'b0, 1'b0},
		'{16'h8000, 16'h4000, 10'h0FF, 1'b1, 1'b1},
		'{16'h0105, 16'h0000, 10'h106, 1'b0, 1'b1}
	};
	logic [7:0] ra [6] = '{8'hC4, 8'hC5, 8'hC6, 8'hC7, CTL, 8'h10};
	logic [7:0] rv [6] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	logic mclk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, conv_start = 1'b0;
	logic win_irq_en = 1'b1;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_r;
	logic [9:0] res = 10'h000, conv_data;
	logic window_hit_flag_r, window_irq_r, conv_busy_r, conv_done_r;
	int n_fail = 0, n_checks = 0, cyc = 0;
	adc_window_comparator #(.SAR_DIV(1)) dut_u (
		.mclk(mclk),
		.rst_n(rst_n),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata),
		.conv_start(conv_start),
		.conv_data(conv_data),
		.win_irq_en(win_irq_en),
		.sfr_rdata_r(sfr_rdata_r),
		.window_hit_flag_r(window_hit_flag_r),
		.window_irq_r(window_irq_r),
		.conv_busy_r(conv_busy_r),
		.conv_done_r(conv_done_r)
	);
	adc_result_src src_u (.busy(conv_busy_r), .value(res), .conv_data(conv_data));
	// Clock and hang guard
	always #2 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		if (g !== e)
			n_fail++;
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge mclk);
		#1 sfr_wr = 1'b0;
		@(posedge mclk);
		#1;
	endtask : wr
	task automatic rd8(input logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge mclk);
		#1 sfr_rd = 1'b0;
		@(posedge mclk);
		#1;
	endtask : rd8
	task automatic conv();
		conv_start = 1'b1;
		@(posedge mclk);
		#1 conv_start = 1'b0;
		repeat (CW) @(posedge mclk);
		#1;
	endtask : conv
	task automatic summarize();
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// Table cases, then reset, refusals and software flag
	initial
	begin
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		foreach (rows[i])
		begin
			res = rows[i].r;
			wr(8'hC4, rows[i].u[7:0]);
			wr(adc_window_pkg::UPPER_HI_ADDR, rows[i].u[15:8]);
			wr(8'hC6, rows[i].l[7:0]);
			wr(8'hC7, rows[i].l[15:8]);
			wr(CTL, {7'h40, rows[i].lj});
			conv();
			chk(window_irq_r, rows[i].hit);
			rd8(CTL);
			chk(sfr_rdata_r, {6'h28, rows[i].hit, rows[i].lj});
		end
		conv_start = 1'b1;
		@(posedge mclk);
		#1 rst_n = 1'b0;
		conv_start = 1'b0;
		@(posedge mclk);
		#1 rst_n = 1'b1;
		chk(conv_busy_r, 1'b0);
		foreach (ra[i])
		begin
			rd8(ra[i]);
			chk(sfr_rdata_r, rv[i]);
		end
		conv();
		chk(conv_busy_r, 1'b0);
		chk(conv_done_r, 1'b0);
		win_irq_en = 1'b0;
		res = 10'h3FF;
		// Enable first: a start bit only counts once the enable bit is set
		wr(CTL, 8'h80);
		wr(CTL, 8'h90);
		chk(conv_busy_r, 1'b1);
		conv();
		chk(conv_done_r, 1'b1);
		rd8(CTL);
		chk(sfr_rdata_r, 8'hA0);
		wr(CTL, 8'h82);
		chk(conv_done_r, 1'b0);
		chk(window_hit_flag_r, 1'b1);
		chk(window_irq_r, 1'b0);
		win_irq_en = 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk(window_irq_r, 1'b1);
		summarize();
	end
endmodule : adc_window_comparator_tb_top
`default_nettype wire
